// ### hw/uart_rx_map.svh
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

// ************************************
// Register offsets
// ************************************
`define OFS_CONTROL 8'h00
`define OFS_IRQ_ENABLE 8'h04
`define OFS_STATUS_ONE 8'h08
`define OFS_STATUS_TWO 8'h0C
`define OFS_DATA 8'h10
`define OFS_BAUD 8'h14

// ************************************
// Control field positions
// ************************************
`define CTL_RX_ON 0
`define CTL_POL_FLIP 1
`define CTL_SLEEP 2
`define CTL_ADDR_MARK 3
`define CTL_KEEP_IDLE 4
`define CTL_IDLE_AFTER_STOP 5
`define CTL_TWO_STOP 6
`define CTL_NINE_BIT 7
`define CTL_PARITY_ON 8
`define CTL_PARITY_ODD 9

// ************************************
// Enable and status field positions
// ************************************
`define IE_TX_EMPTY 0
`define IE_TX_DONE 1
`define IE_RX_FULL 2
`define IE_IDLE 3
`define IE_EDGE 4
`define IE_BREAK 5
`define IE_OVERRUN 6
`define IE_NOISE 7
`define IE_FRAMING 8
`define IE_PARITY 9
`define IE_FULL_DMA 10
`define IE_IDLE_DMA 11
`define ST2_EDGE 0
`define ST2_BREAK 1

// ************************************
// Reset values and sample slots
// ************************************
`define RST_CONTROL 10'h000
`define RST_IRQ_ENABLE 12'h000
`define RST_BAUD 13'h0004
`define SLOT_3 4'h3
`define SLOT_5 4'h5
`define SLOT_7 4'h7
`define SLOT_8 4'h8
`define SLOT_9 4'h9
`define SLOT_10 4'hA
`define SLOT_16 4'h0
`define SLOT_LATE 4'hB
`define SLOTS_PER_BIT 8'h10
`endif

// ### hw/uart_rx_pkg.sv
package uart_rx_pkg;
    typedef enum logic [1:0] {
        HUNT = 2'b00,
        START_CHECK = 2'b01,
        FRAME = 2'b10
    } rx_state_e;
    typedef logic [7:0] apb_addr_t;
    typedef logic [8:0] rx_char_t;
endpackage

// ### hw/baud_tick.sv
`timescale 1ns/1ns
module baud_tick #(
    parameter int W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [W-1:0] div,
    output logic tick
);
    logic [W-1:0] cnt_q;

    initial begin
        if (W < 1 || W > 16) begin
            $error("baud_tick width out of range");
        end
    end

    // Divider for the sixteen-per-bit sample enable; zero acts as one
    assign tick = run && (cnt_q + 1'b1 >= div);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!run || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// ### hw/bit_vote.sv
`timescale 1ns/1ns
module bit_vote (
    input wire logic [2:0] samples,
    output logic level,
    output logic disagree
);
    // Two of three decide the level; any split is noise
    assign level = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
    assign disagree = (samples != 3'b000) && (samples != 3'b111);
endmodule

// ### hw/uart_rx.sv
`timescale 1ns/1ns
`include "uart_rx_map.svh"
// Notes on behaviour
// R1: Optional receive-line inversion precedes all sampling.
// R2: Start low, 8/9 data LSB first, 1/2 stops.
// R3: Completed character loads empty buffer, sets full.
// R4: Full buffer: overrun set, character and errors dropped.
// R5: Sixteen samples per bit; edge is 1-1-1-0.
// R6: Start accepted when two of slots 3,5,7 low.
// R7: Every data and stop bit decided by majority of slots 8-10.
// R8: Any disagreeing sample sets noise on load.
// R9: Every detected edge outside start check realigns the slot timing.
// R10: Non-break framing error preloads three high samples.
// R11: Framing flag set blocks further buffer loads.
// R12: Sleep blocks receiver flags, idle optionally excepted.
// R13: Idle-line mode wakes after full character idle.
// R14: Waking idle sets idle flag only when kept.
// R15: Idle count starts after start or stop bit.
// R16: Address mark wakes before stops, character received.
// R17: Three requests, ten separately masked sources.
// R18: Transmit request from empty or complete, each enabled.
// R19: Status read then data read clears full.
// R20: Idle clears likewise; rearms only after new character.
// R21: Noise, framing, parity set with full, never overrun.
// R22: Edge flag set while enabled; write one clears.
// R23: DMA-routed flags clear only on DMA completion.
module uart_rx #(
    parameter int BAUD_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire uart_rx_pkg::apb_addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_line,
    input wire logic tx_empty_flag,
    input wire logic tx_complete,
    input wire logic rx_dma_done,
    input wire logic idle_dma_done,
    output logic irq_tx,
    output logic irq_rx,
    output logic irq_err,
    output logic rx_dma_req,
    output logic idle_dma_req
);
    import uart_rx_pkg::*;

    initial begin
        if (BAUD_W < 4 || BAUD_W > 16) begin
            $error("uart_rx baud width out of range");
        end
    end

    // ************************************
    // Declarations
    // ************************************
    logic [9:0] ctl_q;
    logic [11:0] ie_q;
    logic [BAUD_W-1:0] baud_q;
    rx_char_t data_q;
    logic rx_full_flag, idle_flag, overrun_flag, noise_flag, framing_error_flag, parity_error_flag;
    logic rx_edge_flag, break_detect_flag, rd_armed_q;
    rx_state_e state_q;
    logic [3:0] rt_q;
    logic [3:0] idx_q;
    logic [2:0] hist_q;
    logic [1:0] vs_q;
    logic early_dis_q, noise_acc_q, fe_acc_q, line_prev_q, idle_armed_q;
    rx_char_t shift_q;
    logic [7:0] idle_cnt_q;
    logic tick, s, edge_seen, vote_level, vote_dis, advance, complete;
    logic wake_mark, wake_idle, idle_hit, load_ok, overrun_ev, is_break;
    logic wr, rd, rd_status, rd_data, line_fall;
    logic [3:0] data_bits, last_idx;
    logic [7:0] idle_thr;
    rx_char_t rx_char;
    logic parity_bad;

    wire rx_on = ctl_q[`CTL_RX_ON];
    wire receiver_sleep = ctl_q[`CTL_SLEEP];
    wire sleep_keeps_idle_flag = ctl_q[`CTL_KEEP_IDLE];
    wire idle_count_after_stop = ctl_q[`CTL_IDLE_AFTER_STOP];
    wire two_stop_select = ctl_q[`CTL_TWO_STOP];
    wire nine_bit = ctl_q[`CTL_NINE_BIT];
    wire full_dma = ie_q[`IE_FULL_DMA];
    wire idle_dma = ie_q[`IE_IDLE_DMA];

    // ************************************
    // APB access decode
    // ************************************
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign rd_status = rd && (paddr == `OFS_STATUS_ONE);
    assign rd_data = rd && (paddr == `OFS_DATA);

    // Unmapped addresses answer with an error and zero data
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `OFS_CONTROL) begin
            prdata = {22'h000000, ctl_q};
        end else if (paddr == `OFS_IRQ_ENABLE) begin
            prdata = {20'h00000, ie_q};
        end else if (paddr == `OFS_STATUS_ONE) begin
            prdata = {23'h000000, state_q != HUNT, parity_error_flag, framing_error_flag, noise_flag,
                      overrun_flag, idle_flag, rx_full_flag, tx_complete, tx_empty_flag};
        end else if (paddr == `OFS_STATUS_TWO) begin
            prdata = {30'h00000000, break_detect_flag, rx_edge_flag};
        end else if (paddr == `OFS_DATA) begin
            prdata = {23'h000000, data_q};
        end else if (paddr == `OFS_BAUD) begin
            prdata = {{(32 - BAUD_W){1'b0}}, baud_q};
        end else begin
            pslverr = psel && penable;
        end
    end

    // Control register; hardware wakeup clears sleep unless software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `RST_CONTROL;
        end else if (wr && paddr == `OFS_CONTROL) begin
            ctl_q <= pwdata[9:0];
        end else if (wake_mark || wake_idle) begin
            ctl_q[`CTL_SLEEP] <= 1'b0; // R13 R16
        end
    end

    // Enables, DMA selects and divisor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= `RST_IRQ_ENABLE;
            baud_q <= BAUD_W'(`RST_BAUD);
        end else if (wr && paddr == `OFS_IRQ_ENABLE) begin
            ie_q <= pwdata[11:0];
        end else if (wr && paddr == `OFS_BAUD) begin
            baud_q <= pwdata[BAUD_W-1:0];
        end
    end

    // ************************************
    // Sampling and frame timing
    // ************************************
    baud_tick #(.W(BAUD_W)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(rx_on),
        .div(baud_q),
        .tick(tick)
    );

    assign s = rx_line ^ ctl_q[`CTL_POL_FLIP]; // R1
    assign edge_seen = tick && (hist_q == 3'b111) && !s; // R5
    assign data_bits = nine_bit ? 4'h9 : 4'h8;
    assign last_idx = data_bits + (two_stop_select ? 4'h2 : 4'h1); // R2
    assign idle_thr = 8'(({4'h0, last_idx} + 8'h01) * `SLOTS_PER_BIT);

    bit_vote u_vote (
        .samples({vs_q, s}),
        .level(vote_level),
        .disagree(vote_dis)
    );

    // Bit boundary at slot 16, or early when an edge lands late in a bit
    assign advance = tick && (state_q == FRAME) && (rt_q == `SLOT_16 || (edge_seen && rt_q >= `SLOT_LATE)); // R9
    assign complete = tick && (state_q == FRAME) && (rt_q == `SLOT_10) && (idx_q == last_idx);

    // Edge search history, preloaded high after a non-break framing error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_q <= 3'b000;
        end else if (!rx_on) begin
            hist_q <= 3'b000;
        end else if (complete && (fe_acc_q || !vote_level) && !is_break) begin
            hist_q <= 3'b111; // R10
        end else if (tick) begin
            hist_q <= {hist_q[1:0], s};
        end
    end

    // Slot counter; every detected edge outside START_CHECK restarts it at slot 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_q <= 4'h0;
        end else if (tick) begin
            if (edge_seen && state_q != START_CHECK) begin
                rt_q <= 4'h2; // R9
            end else begin
                rt_q <= rt_q + 4'h1;
            end
        end
    end

    // Sample holder for slots 3,5 and 8,9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_q <= 2'b00;
        end else if (tick && (rt_q == `SLOT_3 || rt_q == `SLOT_5 || rt_q == `SLOT_8 || rt_q == `SLOT_9)) begin
            vs_q <= {vs_q[0], s}; // R7
        end
    end

    // Receive state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= HUNT;
            idx_q <= 4'h0;
        end else if (!rx_on) begin
            state_q <= HUNT;
            idx_q <= 4'h0;
        end else if (tick) begin
            case (state_q)
                HUNT: begin
                    if (edge_seen) begin
                        state_q <= START_CHECK;
                    end
                end
                START_CHECK: begin
                    if (rt_q == `SLOT_7 && vote_level) begin
                        state_q <= HUNT; // R6
                    end else if (rt_q == `SLOT_16) begin
                        state_q <= FRAME;
                        idx_q <= 4'h1;
                    end
                end
                FRAME: begin
                    if (complete) begin
                        state_q <= HUNT;
                    end else if (advance) begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= HUNT;
                end
            endcase
        end
    end

    // Shifter, noise and framing accumulation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 9'h000;
            early_dis_q <= 1'b0;
            noise_acc_q <= 1'b0;
            fe_acc_q <= 1'b0;
        end else if (tick && state_q == START_CHECK) begin
            if (rt_q == `SLOT_7) begin
                early_dis_q <= vote_dis;
                noise_acc_q <= 1'b0;
                fe_acc_q <= 1'b0;
            end else if (rt_q == `SLOT_10) begin
                noise_acc_q <= early_dis_q || ({vs_q, s} != 3'b000); // R6 R8
            end
        end else if (tick && state_q == FRAME && rt_q == `SLOT_10) begin
            noise_acc_q <= noise_acc_q || vote_dis; // R8
            if (idx_q <= data_bits) begin
                shift_q <= {vote_level, shift_q[8:1]}; // R2
            end else if (!vote_level) begin
                fe_acc_q <= 1'b1;
            end
        end
    end

    // Address mark: top bit, or top two with two stops, wakes a sleeper
    assign wake_mark = tick && state_q == FRAME && rt_q == `SLOT_10 && idx_q == data_bits && receiver_sleep &&
                       ctl_q[`CTL_ADDR_MARK] && vote_level && (!two_stop_select || shift_q[8]); // R16

    // ************************************
    // Character completion
    // ************************************
    assign rx_char = nine_bit ? shift_q : {1'b0, shift_q[8:1]};
    assign parity_bad = ctl_q[`CTL_PARITY_ON] && ((^rx_char) != ctl_q[`CTL_PARITY_ODD]);
    assign is_break = (rx_char == 9'h000) && (fe_acc_q || !vote_level);
    assign load_ok = complete && !receiver_sleep && !framing_error_flag && !rx_full_flag; // R3 R11 R12
    assign overrun_ev = complete && !receiver_sleep && !framing_error_flag && rx_full_flag; // R4

    // Receive buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 9'h000;
        end else if (load_ok) begin
            data_q <= rx_char; // R3
        end
    end

    // Status then data read sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_armed_q <= 1'b0;
        end else if (rd_status && (rx_full_flag || idle_flag)) begin
            rd_armed_q <= 1'b1; // R19
        end else if (rd_data) begin
            rd_armed_q <= 1'b0;
        end
    end

    wire seq_clear = rd_data && rd_armed_q;

    // Full flag; DMA routing replaces the read sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_flag <= 1'b0;
        end else if (load_ok) begin
            rx_full_flag <= 1'b1; // R3
        end else if (full_dma ? rx_dma_done : seq_clear) begin
            rx_full_flag <= 1'b0; // R19 R23
        end
    end

    // Noise, framing and parity flags load with the character, never on overrun; the overrun flag sets on overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (load_ok) begin
                noise_flag <= noise_acc_q || vote_dis; // R8 R21
                framing_error_flag <= fe_acc_q || !vote_level; // R21
                parity_error_flag <= parity_bad; // R21
            end else if (seq_clear) begin
                noise_flag <= 1'b0;
                framing_error_flag <= 1'b0;
                parity_error_flag <= 1'b0;
            end
            if (overrun_ev) begin
                overrun_flag <= 1'b1; // R4
            end else if (seq_clear) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // ************************************
    // Idle detection and wakeup
    // ************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_q <= 8'h00;
        end else if (!rx_on || (tick && !s)) begin
            idle_cnt_q <= 8'h00;
        end else if (tick && (state_q == HUNT || (state_q == FRAME && !idle_count_after_stop))) begin
            if (idle_cnt_q != idle_thr) begin
                idle_cnt_q <= idle_cnt_q + 8'h01; // R15
            end
        end else if (tick && state_q != HUNT) begin
            idle_cnt_q <= 8'h00; // R15
        end
    end

    assign idle_hit = tick && s && (idle_cnt_q + 8'h01 == idle_thr); // R13
    assign wake_idle = idle_hit && receiver_sleep && !ctl_q[`CTL_ADDR_MARK]; // R13

    // Idle rearms only after a character has set the full flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_armed_q <= 1'b0;
        end else if (load_ok) begin
            idle_armed_q <= 1'b1; // R20
        end else if (idle_hit && (!receiver_sleep || sleep_keeps_idle_flag)) begin
            idle_armed_q <= 1'b0;
        end
    end

    // Idle flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_flag <= 1'b0;
        end else if (idle_hit && idle_armed_q && (!receiver_sleep || sleep_keeps_idle_flag)) begin
            idle_flag <= 1'b1; // R12 R14
        end else if (idle_dma ? idle_dma_done : seq_clear) begin
            idle_flag <= 1'b0; // R20 R23
        end
    end

    // ************************************
    // Edge and break flags
    // ************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev_q <= 1'b1;
        end else begin
            line_prev_q <= s;
        end
    end

    assign line_fall = rx_on && line_prev_q && !s && !receiver_sleep; // R12 R22

    // Write-one-to-clear flags; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_edge_flag <= 1'b0;
            break_detect_flag <= 1'b0;
        end else begin
            if (line_fall) begin
                rx_edge_flag <= 1'b1; // R22
            end else if (wr && paddr == `OFS_STATUS_TWO && pwdata[`ST2_EDGE]) begin
                rx_edge_flag <= 1'b0; // R22
            end
            if (complete && is_break && !receiver_sleep) begin
                break_detect_flag <= 1'b1; // R12
            end else if (wr && paddr == `OFS_STATUS_TWO && pwdata[`ST2_BREAK]) begin
                break_detect_flag <= 1'b0;
            end
        end
    end

    // ************************************
    // Request outputs
    // ************************************
    assign irq_tx = (tx_empty_flag && ie_q[`IE_TX_EMPTY]) || (tx_complete && ie_q[`IE_TX_DONE]); // R18
    assign irq_rx = (rx_full_flag && ie_q[`IE_RX_FULL] && !full_dma) || (idle_flag && ie_q[`IE_IDLE] && !idle_dma) ||
                    (rx_edge_flag && ie_q[`IE_EDGE]) || (break_detect_flag && ie_q[`IE_BREAK]); // R17
    assign irq_err = (overrun_flag && ie_q[`IE_OVERRUN]) || (noise_flag && ie_q[`IE_NOISE]) ||
                     (framing_error_flag && ie_q[`IE_FRAMING]) || (parity_error_flag && ie_q[`IE_PARITY]); // R17
    assign rx_dma_req = rx_full_flag && ie_q[`IE_RX_FULL] && full_dma; // R23
    assign idle_dma_req = idle_flag && ie_q[`IE_IDLE] && idle_dma; // R23
endmodule

// ### testbench/uart_rx_asserts.sv
`timescale 1ns/1ns
`include "uart_rx_map.svh"
module uart_rx_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire uart_rx_pkg::apb_addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic tx_empty_flag,
    input wire logic tx_complete,
    input wire logic rx_dma_done,
    input wire logic irq_tx,
    input wire logic irq_rx,
    input wire logic irq_err,
    input wire logic rx_dma_req
);
    import uart_rx_pkg::*;
    logic acc, ie_wr, known;
    logic [11:0] ie_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access-phase decode
    assign acc = psel && penable;
    assign ie_wr = acc && pwrite && paddr == `OFS_IRQ_ENABLE;
    assign known = paddr inside {`OFS_CONTROL, `OFS_IRQ_ENABLE, `OFS_STATUS_ONE,
        `OFS_STATUS_TWO, `OFS_DATA, `OFS_BAUD};
    // Copy of the enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= 12'h000;
        end else if (ie_wr) begin
            ie_q <= pwdata[11:0];
        end
    end
    // Bus decode and request outputs
    unmapped_err_a: assert property (acc && !known |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    tx_status_a: assert property (acc && !pwrite && paddr == `OFS_STATUS_ONE
        |-> prdata[1:0] == {tx_complete, tx_empty_flag}) else $error("tx status bits wrong");
    irq_tx_a: assert property (irq_tx == (ie_q[0] && tx_empty_flag || ie_q[1] && tx_complete))
        else $error("tx request wrong");
    irq_err_a: assert property (irq_err |-> ie_q[9:6] != 4'h0)
        else $error("error request unmasked");
    irq_rx_a: assert property (irq_rx |-> ie_q[5:2] != 4'h0)
        else $error("rx request unmasked");
    dma_hold_a: assert property (rx_dma_req && !rx_dma_done && !ie_wr |=> rx_dma_req)
        else $error("dma request dropped");
    dma_done_a: assert property (rx_dma_req && rx_dma_done |=> !rx_dma_req)
        else $error("dma request not cleared");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq_rx && !irq_err && !rx_dma_req)
        else $error("requests after reset");
endmodule

// ### testbench/serial_source.sv
`timescale 1ns/1ns
module serial_source #(
    parameter int BIT = 64
) (
    input wire logic pclk,
    input wire logic inv,
    output logic line
);
    logic raw_q = 1'h1;
    // Idle high, flipped on the wire when asked
    assign line = raw_q ^ inv;
    // Level v for n cycles; g flips one sample-wide slice near mid-bit
    task automatic put(input logic v, input logic g, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            raw_q <= (g && i >= 34 && i < 38) ? !v : v;
        end
    endtask
    // Idle bit time, start, eight data bits LSB first, one stop; a low stop ends early
    task automatic send(input logic [7:0] d, input logic stp, input logic g);
        put(1'h1, 1'h0, BIT);
        put(1'h0, 1'h0, BIT);
        for (int b = 0; b < 8; b++) begin
            put(d[b], g && b == 0, BIT);
        end
        put(stp, 1'h0, stp ? BIT : 44);
        @(posedge pclk);
        raw_q <= 1'h1;
    endtask
endmodule

// ### testbench/tb_uart_receiver_sampling_wakeup.sv
`timescale 1ns/1ns
`include "uart_rx_map.svh"
module tb_uart_receiver_sampling_wakeup;
    import uart_rx_pkg::*;
    typedef struct packed {
        apb_addr_t a;
        logic [31:0] d;
        logic e;
    } row_s;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, inv = 1'h0;
    logic tx_empty_flag = 1'h1, tx_complete = 1'h0, rx_dma_done = 1'h0, idle_dma_done = 1'h0;
    apb_addr_t paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, irq_tx, irq_rx, irq_err, rx_dma_req, idle_dma_req, rx_line, serr;
    int n_errors = 0, comparisons = 0, cycles = 0;
    row_s rows [7] = '{'{`OFS_CONTROL, 32'h0, 1'h0}, '{`OFS_IRQ_ENABLE, 32'h0, 1'h0},
        '{`OFS_STATUS_ONE, 32'h1, 1'h0}, '{`OFS_STATUS_TWO, 32'h0, 1'h0},
        '{`OFS_DATA, 32'h0, 1'h0}, '{`OFS_BAUD, 32'h4, 1'h0}, '{8'h18, 32'h0, 1'h1}};
    // Design and far-end transmitter
    uart_rx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line(rx_line), .tx_empty_flag(tx_empty_flag), .tx_complete(tx_complete),
        .rx_dma_done(rx_dma_done), .idle_dma_done(idle_dma_done), .irq_tx(irq_tx), .irq_rx(irq_rx),
        .irq_err(irq_err), .rx_dma_req(rx_dma_req), .idle_dma_req(idle_dma_req));
    serial_source src (.pclk(pclk), .inv(inv), .line(rx_line));
    // Clock and hang guard
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, then one idle cycle
    task automatic xfer(input apb_addr_t a, input logic w, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rdc(input apb_addr_t a, input logic [31:0] m, input logic [31:0] exp);
        xfer(a, 1'h0, 32'h0);
        chk(rdata & m, exp);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (rows[i]) begin
            rdc(rows[i].a, 32'hFFFFFFFF, rows[i].d);
            chk({31'h0, serr}, {31'h0, rows[i].e});
        end
        // Plain character, read pair, edge flag
        xfer(`OFS_CONTROL, 1'h1, 32'h1);
        src.send(8'hA5, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h04);
        rdc(`OFS_DATA, 32'h1FF, 32'hA5);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h00);
        rdc(`OFS_STATUS_TWO, 32'h1, 32'h1);
        xfer(`OFS_STATUS_TWO, 1'h1, 32'h1);
        rdc(`OFS_STATUS_TWO, 32'h1, 32'h0);
        // Overrun keeps the first character
        src.send(8'h3C, 1'h1, 1'h0);
        src.send(8'h55, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h14);
        rdc(`OFS_DATA, 32'h1FF, 32'h3C);
        // Noisy sample, then a low stop bit
        src.send(8'h6A, 1'h1, 1'h1);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h24);
        rdc(`OFS_DATA, 32'h1FF, 32'h6A);
        src.send(8'h5A, 1'h0, 1'h0);
        src.send(8'h77, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h44);
        rdc(`OFS_DATA, 32'h1FF, 32'h5A);
        // Flipped line, idle flag after a character time
        xfer(`OFS_CONTROL, 1'h1, 32'h0);
        inv <= 1'h1;
        xfer(`OFS_CONTROL, 1'h1, 32'h3);
        src.send(8'hC3, 1'h1, 1'h0);
        repeat (704) @(posedge pclk);
        rdc(`OFS_STATUS_ONE, 32'hFC, 32'h0C);
        rdc(`OFS_DATA, 32'h1FF, 32'hC3);
        rdc(`OFS_STATUS_ONE, 32'h08, 32'h00);
        xfer(`OFS_CONTROL, 1'h1, 32'h0);
        inv <= 1'h0;
        // Idle-line wake drops the sleeping character
        xfer(`OFS_CONTROL, 1'h1, 32'h5);
        src.send(8'h11, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h00);
        repeat (640) @(posedge pclk);
        rdc(`OFS_CONTROL, 32'h4, 32'h0);
        rdc(`OFS_STATUS_ONE, 32'h08, 32'h00);
        // Address-mark wake
        xfer(`OFS_CONTROL, 1'h1, 32'hD);
        src.send(8'h12, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h00);
        src.send(8'h92, 1'h1, 1'h0);
        rdc(`OFS_CONTROL, 32'h4, 32'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h04);
        rdc(`OFS_DATA, 32'h1FF, 32'h92);
        // DMA-routed full flag ignores the read pair
        xfer(`OFS_CONTROL, 1'h1, 32'h1);
        xfer(`OFS_IRQ_ENABLE, 1'h1, 32'h405);
        src.send(8'h3C, 1'h1, 1'h0);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h04);
        rdc(`OFS_DATA, 32'h1FF, 32'h3C);
        chk({31'h0, rx_dma_req}, 32'h1);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h04);
        rx_dma_done <= 1'h1;
        @(posedge pclk);
        rx_dma_done <= 1'h0;
        @(posedge pclk);
        rdc(`OFS_STATUS_ONE, 32'hF4, 32'h00);
        chk({31'h0, rx_dma_req}, 32'h0);
        close_out();
    end
endmodule

bind uart_rx uart_rx_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .tx_empty_flag(tx_empty_flag), .tx_complete(tx_complete), .rx_dma_done(rx_dma_done),
    .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err), .rx_dma_req(rx_dma_req));
